// ---- src/spc_consts.svh ----
// Operation
// - code 08h for 720p 24-frame, 09h extended; 4125 samples per line
// - code 0Fh for 1080 25 segmented-frame extended; 2640 samples
// - code 0Eh for 1080 25 progressive extended; 2304 active words
// - code 13h for 1080 24 segmented extended; family 10h-13h has 2750
// - code 12h for 1080 24 progressive extended; 2400 active words
// - code 16h for 525-line (1716 samples), 18h for 625-line (1728)
// - 59.94 and 60 hz variants share one code, never told apart
// - insertion works only with processing enable and smpte mode pins high
// - disable bits clear on reset; writing a one to bits 0 to 6 disables that feature
// - bit 8 low: h input follows line blanking; high: follows trs h bit
// - bit 6 low in hd: payload id in luma only, if a format byte nonzero
// - bit 5 low: detect and correct illegal codes in active picture
// - bit 4 low in sd mode: generate and insert edh packets
// - bit 3 low: compute and insert ancillary packet checksums
// - bit 2 low in hd mode: insert line crc in luma and chroma
// - bit 1 low: insert line numbers in luma and chroma, hd only
// - bit 0 low: insert trs words, only with both mode pins high
// - 5-bit standard code in bits 14 to 10 of read-only status at 004h
// - code and interlace bit read zero while smpte mode or lock is low
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// ************************************************
// register map
// ************************************************
`define SPC_ADDR_W 12
`define SPC_DATA_W 16
`define SPC_ADDR_DISABLE 12'h000
`define SPC_ADDR_STATUS 12'h004
`define SPC_DISABLE_RESET 16'h0000
`define SPC_DISABLE_MASK 16'h017f
`define SPC_BIT_TRS 0
`define SPC_BIT_LNUM 1
`define SPC_BIT_CRC 2
`define SPC_BIT_CSUM 3
`define SPC_BIT_EDH 4
`define SPC_BIT_REMAP 5
`define SPC_BIT_PID 6
`define SPC_BIT_HCFG 8
`define SPC_ST_CODE_LO 10
`define SPC_ST_INTERLACE 9
`define SPC_ST_LOCK 8

// ************************************************
// raster figures and standard codes
// ************************************************
`define SPC_TOT_720_60 13'd1650
`define SPC_TOT_720_30 13'd3300
`define SPC_TOT_720_50 13'd1980
`define SPC_TOT_720_25 13'd3960
`define SPC_TOT_720_24 13'd4125
`define SPC_TOT_1080_30 13'd2200
`define SPC_TOT_1080_25 13'd2640
`define SPC_TOT_1080_24 13'd2750
`define SPC_TOT_1080_295 13'd2376
`define SPC_TOT_525 13'd1716
`define SPC_TOT_625 13'd1728
`define SPC_ACT_720 12'd1280
`define SPC_ACT_1080_25EM 12'd2304
`define SPC_ACT_1080_24EM 12'd2400
`define SPC_ACT_1080 12'd1920
`define SPC_ACT_SD 12'd1440
`define SPC_LINES_1035 11'd1035
`define SPC_LINES_507 11'd507
`define SPC_STD_720_24 5'h08
`define SPC_STD_1080I_30 5'h0a
`define SPC_STD_1080P_30 5'h0b
`define SPC_STD_1080I_25 5'h0c
`define SPC_STD_1080P_25 5'h0d
`define SPC_STD_1080P_25EM 5'h0e
`define SPC_STD_1080S_25EM 5'h0f
`define SPC_STD_1080P_24 5'h10
`define SPC_STD_1080S_24 5'h11
`define SPC_STD_1080P_24EM 5'h12
`define SPC_STD_1080S_24EM 5'h13
`define SPC_STD_1080_295 5'h14
`define SPC_STD_1035 5'h15
`define SPC_STD_525_487 5'h16
`define SPC_STD_525_507 5'h17
`define SPC_STD_625 5'h18
`define SPC_STD_525_487G 5'h19
`define SPC_STD_625G 5'h1a
`define SPC_STD_525_507G 5'h1b
`define SPC_STD_UNK_HD 5'h1d
`define SPC_STD_UNK_SD 5'h1e

`define SPC_PIN_PROC 0
`define SPC_PIN_SMPTE 1
`define SPC_PIN_LOCK 2
`define SPC_NUM_PINS 3

`endif

// ---- src/spc_pkg.sv ----
`include "spc_consts.svh"

package spc_pkg;

	// ************************************************
	// carriers
	// ************************************************
	typedef struct packed {
		logic [`SPC_ADDR_W-1:0] addr;
		logic [`SPC_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} spc_bus_req_t;

	typedef struct packed {
		logic hd;
		logic interlaced;
		logic psf;
		logic [12:0] total_samples;
		logic [11:0] active_words;
		logic [10:0] active_lines;
	} spc_raster_t;

	typedef struct packed {
		logic h_follows_trs;
		logic payload_id_luma;
		logic remap;
		logic edh;
		logic anc_checksum;
		logic line_crc;
		logic line_number;
		logic trs;
	} spc_feature_en_t;

	typedef struct packed {
		logic [`SPC_NUM_PINS-1:0][2:0] sync;
		logic [`SPC_NUM_PINS-1:0] pin_q;
		logic [`SPC_DATA_W-1:0] disable_bits;
		logic [4:0] code;
		logic interlace;
		logic [`SPC_DATA_W-1:0] rdata;
		spc_feature_en_t feat;
	} spc_ctrl_state_t;

endpackage

// ---- src/spc_std_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.svh"

module spc_std_detect (
	input wire spc_pkg::spc_raster_t raster_in,
	output logic [4:0] code_out,
	output logic interlace_out
);
	import spc_pkg::*;

	logic ext;
	logic seg;
	logic tall;

	// ************************************************
	// raster to standard code
	// ************************************************
	// frame rate is never measured, so 59.94 and 60 share a code
	always_comb begin
		ext = raster_in.active_words != `SPC_ACT_SD;
		seg = raster_in.interlaced | raster_in.psf;
		tall = raster_in.active_lines >= `SPC_LINES_507;
		interlace_out = raster_in.interlaced;
		code_out = raster_in.hd ? `SPC_STD_UNK_HD : `SPC_STD_UNK_SD;
		if (raster_in.hd) begin
			case (raster_in.total_samples)
				`SPC_TOT_720_60: code_out = {4'h0, raster_in.active_words != `SPC_ACT_720};
				`SPC_TOT_720_30: code_out = {4'h1, raster_in.active_words != `SPC_ACT_720};
				`SPC_TOT_720_50: code_out = {4'h2, raster_in.active_words != `SPC_ACT_720};
				`SPC_TOT_720_25: code_out = {4'h3, raster_in.active_words != `SPC_ACT_720};
				`SPC_TOT_720_24: code_out = {4'h4,
					raster_in.active_words != `SPC_ACT_720};
				`SPC_TOT_1080_30: begin
					if (raster_in.active_lines == `SPC_LINES_1035)
						code_out = `SPC_STD_1035;
					else
						code_out = seg ? `SPC_STD_1080I_30 : `SPC_STD_1080P_30;
				end
				`SPC_TOT_1080_25: begin
					if (raster_in.active_words == `SPC_ACT_1080_25EM)
						code_out = seg ? `SPC_STD_1080S_25EM : `SPC_STD_1080P_25EM;
					else
						code_out = seg ? `SPC_STD_1080I_25 : `SPC_STD_1080P_25;
				end
				`SPC_TOT_1080_24: begin
					if (raster_in.active_words == `SPC_ACT_1080_24EM)
						code_out = seg ? `SPC_STD_1080S_24EM : `SPC_STD_1080P_24EM;
					else
						code_out = seg ? `SPC_STD_1080S_24 : `SPC_STD_1080P_24;
				end
				`SPC_TOT_1080_295: code_out = `SPC_STD_1080_295;
				default: code_out = `SPC_STD_UNK_HD;
			endcase
		end else if (raster_in.total_samples == `SPC_TOT_525) begin
			if (ext)
				code_out = tall ? `SPC_STD_525_507G : `SPC_STD_525_487G;
			else
				code_out = tall ? `SPC_STD_525_507 : `SPC_STD_525_487;
		end else if (raster_in.total_samples == `SPC_TOT_625) begin
			code_out = (raster_in.active_words == `SPC_ACT_SD) ?
				`SPC_STD_625 : `SPC_STD_625G;
		end
	end

endmodule

`default_nettype wire

// ---- src/spc_proc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.svh"

module spc_proc_ctrl (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire spc_pkg::spc_bus_req_t bus_in,
	output logic [`SPC_DATA_W-1:0] rdata_out,
	input wire logic processing_enable_pin_in,
	input wire logic smpte_mode_pin_in,
	input wire logic pll_lock_output_in,
	input wire logic flywheel_lock_in,
	input wire logic payload_format_nonzero_in,
	input wire spc_pkg::spc_raster_t raster_in,
	output spc_pkg::spc_feature_en_t feature_en_out,
	output logic [4:0] video_std_code_out,
	output logic interlace_out
);
	import spc_pkg::*;

	spc_ctrl_state_t st_reg;
	spc_ctrl_state_t st_next;
	logic [4:0] det_code;
	logic det_interlace;
	logic gate;
	logic std_valid;
	logic [`SPC_NUM_PINS-1:0] pins;

	// ************************************************
	// standard detection
	// ************************************************
	spc_std_detect detect_inst (
		.raster_in(raster_in),
		.code_out(det_code),
		.interlace_out(det_interlace)
	);

	assign pins = {pll_lock_output_in, smpte_mode_pin_in,
		processing_enable_pin_in};
	assign gate = st_reg.pin_q[`SPC_PIN_PROC] &
		st_reg.pin_q[`SPC_PIN_SMPTE];
	assign std_valid = st_reg.pin_q[`SPC_PIN_SMPTE] & st_reg.pin_q[`SPC_PIN_LOCK];

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		st_next = st_reg;
		// three stages; a pin change counts once stage two and three agree
		for (int i = 0; i < `SPC_NUM_PINS; i++) begin
			st_next.sync[i] = {st_reg.sync[i][1:0], pins[i]};
			if (st_reg.sync[i][1] == st_reg.sync[i][2])
				st_next.pin_q[i] = st_reg.sync[i][2];
		end
		// host write: only documented bits take a one
		if (bus_in.wr && bus_in.addr == `SPC_ADDR_DISABLE)
			st_next.disable_bits = bus_in.wdata & `SPC_DISABLE_MASK;
		// status clears while mode pin or lock is low
		if (std_valid) begin
			st_next.code = det_code;
			st_next.interlace = det_interlace;
		end else begin
			st_next.code = 5'h00;
			st_next.interlace = 1'b0;
		end
		// read data stands one cycle only, zero elsewhere
		st_next.rdata = 16'h0000;
		if (bus_in.rd) begin
			if (bus_in.addr == `SPC_ADDR_DISABLE) begin
				st_next.rdata = st_reg.disable_bits;
			end else if (bus_in.addr == `SPC_ADDR_STATUS) begin
				st_next.rdata[`SPC_ST_CODE_LO+:5] = st_reg.code;
				st_next.rdata[`SPC_ST_INTERLACE] = st_reg.interlace;
				st_next.rdata[`SPC_ST_LOCK] = flywheel_lock_in;
			end
		end
		// feature enables for the insertion datapaths
		st_next.feat.trs = gate & ~st_reg.disable_bits[`SPC_BIT_TRS];
		st_next.feat.line_number = gate & raster_in.hd &
			~st_reg.disable_bits[`SPC_BIT_LNUM];
		st_next.feat.line_crc = gate & raster_in.hd &
			~st_reg.disable_bits[`SPC_BIT_CRC];
		st_next.feat.anc_checksum = gate &
			~st_reg.disable_bits[`SPC_BIT_CSUM];
		st_next.feat.edh = gate & ~raster_in.hd &
			~st_reg.disable_bits[`SPC_BIT_EDH];
		st_next.feat.remap = gate &
			~st_reg.disable_bits[`SPC_BIT_REMAP];
		// luma only; chroma never carries the payload id
		st_next.feat.payload_id_luma = gate & raster_in.hd &
			payload_format_nonzero_in &
			~st_reg.disable_bits[`SPC_BIT_PID];
		// timing selection is not a packet feature, so no pin gate
		st_next.feat.h_follows_trs = st_reg.disable_bits[`SPC_BIT_HCFG];
	end

	// ************************************************
	// state register
	// ************************************************
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_out = st_reg.rdata;
	assign feature_en_out = st_reg.feat;
	assign video_std_code_out = st_reg.code;
	assign interlace_out = st_reg.interlace;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	reset_clears_a: assert property (
		$past(rst_in) |-> st_reg.disable_bits == 16'h0000 &&
			feature_en_out.h_follows_trs == 1'b0)
		else $error("disable bits not clear after reset");

	write_mask_a: assert property (
		bus_in.wr && bus_in.addr == 12'h000 |=>
			st_reg.disable_bits == ($past(bus_in.wdata) & 16'h017f))
		else $error("disable write stored wrong bits");

	hcfg_follow_a: assert property (
		bus_in.wr && bus_in.addr == 12'h000 && bus_in.wdata[8] ##1
			!bus_in.wr |=> feature_en_out.h_follows_trs)
		else $error("h timing select did not follow bit 8");

	trs_gate_a: assert property (
		feature_en_out.trs |-> $past(gate) &&
			!$past(st_reg.disable_bits[0]))
		else $error("trs insertion without both pins high");

	pid_luma_a: assert property (
		feature_en_out.payload_id_luma |-> $past(raster_in.hd) &&
			$past(payload_format_nonzero_in))
		else $error("payload id outside hd or with empty format");

	edh_sd_a: assert property (
		feature_en_out.edh |-> !$past(raster_in.hd))
		else $error("edh insertion in hd mode");

	lnum_crc_hd_a: assert property (
		feature_en_out.line_number || feature_en_out.line_crc |->
			$past(raster_in.hd))
		else $error("line number or crc insertion in sd mode");

	pin_gate_a: assert property (
		!st_reg.pin_q[0] [*2] |-> !feature_en_out.trs &&
			!feature_en_out.remap && !feature_en_out.anc_checksum)
		else $error("insertion active with processing pin low");

	code_clear_a: assert property (
		!std_valid |=> video_std_code_out == 5'h00 && !interlace_out)
		else $error("standard code not cleared");

	code_720_24_a: assert property (
		std_valid && raster_in.hd && raster_in.total_samples == 13'd4125 &&
			raster_in.active_words == 12'd1280 |=>
			video_std_code_out == 5'h08)
		else $error("720 24 frame code wrong");

	code_1080_24em_a: assert property (
		std_valid && raster_in.hd && raster_in.total_samples == 13'd2750 &&
			raster_in.active_words == 12'd2400 && raster_in.psf &&
			!raster_in.interlaced |=> video_std_code_out == 5'h13)
		else $error("1080 24 segmented extended code wrong");

	code_625_a: assert property (
		std_valid && !raster_in.hd && raster_in.total_samples == 13'd1728 &&
			raster_in.active_words == 12'd1440 |=>
			video_std_code_out == 5'h18)
		else $error("625 line code wrong");

	status_read_a: assert property (
		bus_in.rd && bus_in.addr == 12'h004 |=>
			rdata_out[14:10] == $past(video_std_code_out) &&
			rdata_out[15] == 1'b0 && rdata_out[7:0] == 8'h00)
		else $error("status read does not carry standard code");

	read_one_cycle_a: assert property (
		!bus_in.rd |=> rdata_out == 16'h0000)
		else $error("read data held past its cycle");

	code_720_em_a: assert property (
		std_valid && raster_in.hd && raster_in.total_samples == 13'd4125 &&
			raster_in.active_words == 12'd3600 |=>
			video_std_code_out == 5'h09)
		else $error("720 24 frame extended code wrong");

	code_25_psf_a: assert property (
		std_valid && raster_in.hd && raster_in.total_samples == 13'd2640 &&
			raster_in.active_words == 12'd2304 && raster_in.psf |=>
			video_std_code_out == 5'h0f)
		else $error("1080 25 segmented extended code wrong");

	code_25_prog_a: assert property (
		std_valid && raster_in.hd && raster_in.total_samples == 13'd2640 &&
			raster_in.active_words == 12'd2304 && !raster_in.psf &&
			!raster_in.interlaced |=> video_std_code_out == 5'h0e)
		else $error("1080 25 progressive extended code wrong");

	code_24_prog_a: assert property (
		std_valid && raster_in.hd && raster_in.total_samples == 13'd2750 &&
			raster_in.active_words == 12'd2400 && !raster_in.psf &&
			!raster_in.interlaced |=> video_std_code_out == 5'h12)
		else $error("1080 24 progressive extended code wrong");

	code_24_psf_a: assert property (
		std_valid && raster_in.hd && raster_in.total_samples == 13'd2750 &&
			raster_in.active_words == 12'd1920 && raster_in.psf |=>
			video_std_code_out == 5'h11)
		else $error("1080 24 segmented code wrong");

	code_525_a: assert property (
		std_valid && !raster_in.hd && raster_in.total_samples == 13'd1716 &&
			raster_in.active_words == 12'd1440 &&
			raster_in.active_lines < 11'd507 |=> video_std_code_out == 5'h16)
		else $error("525 line code wrong");

	code_1035_a: assert property (
		std_valid && raster_in.hd && raster_in.total_samples == 13'd2200 &&
			raster_in.active_lines == 11'd1035 |=>
			video_std_code_out == 5'h15)
		else $error("1035 line code wrong");

	code_unk_sd_a: assert property (
		std_valid && !raster_in.hd && raster_in.total_samples != 13'd1716 &&
			raster_in.total_samples != 13'd1728 |=>
			video_std_code_out == 5'h1e)
		else $error("unknown sd raster not flagged");

	remap_gate_a: assert property (
		feature_en_out.remap |-> $past(gate) &&
			!$past(st_reg.disable_bits[5]))
		else $error("remap active while disabled or ungated");

	csum_gate_a: assert property (
		feature_en_out.anc_checksum |-> $past(gate) &&
			!$past(st_reg.disable_bits[3]))
		else $error("checksum active while disabled or ungated");

	crc_gate_a: assert property (
		feature_en_out.line_crc |-> $past(gate) &&
			!$past(st_reg.disable_bits[2]))
		else $error("line crc active while disabled or ungated");

	lnum_gate_a: assert property (
		feature_en_out.line_number |-> $past(gate) &&
			!$past(st_reg.disable_bits[1]))
		else $error("line number active while disabled or ungated");

	trs_on_a: assert property (
		gate && !st_reg.disable_bits[0] |=> feature_en_out.trs)
		else $error("trs insertion missing while enabled");

	edh_on_a: assert property (
		gate && !raster_in.hd && !st_reg.disable_bits[4] |=>
			feature_en_out.edh)
		else $error("edh insertion missing in sd mode");

	crc_on_a: assert property (
		gate && raster_in.hd && !st_reg.disable_bits[2] |=>
			feature_en_out.line_crc)
		else $error("line crc missing in hd mode");

	lnum_on_a: assert property (
		gate && raster_in.hd && !st_reg.disable_bits[1] |=>
			feature_en_out.line_number)
		else $error("line number missing in hd mode");

	pid_on_a: assert property (
		gate && raster_in.hd && payload_format_nonzero_in &&
			!st_reg.disable_bits[6] |=> feature_en_out.payload_id_luma)
		else $error("payload id missing while enabled");

	smpte_gate_a: assert property (
		!st_reg.pin_q[1] [*2] |-> feature_en_out[6:0] == 7'h00)
		else $error("insertion active with smpte mode low");

	hcfg_low_a: assert property (
		!st_reg.disable_bits[8] |=> !feature_en_out.h_follows_trs)
		else $error("h timing select high with bit 8 low");

	disable_hold_a: assert property (
		!(bus_in.wr && bus_in.addr == 12'h000) |=>
			$stable(st_reg.disable_bits))
		else $error("disable bits changed without a write");

	disable_read_a: assert property (
		bus_in.rd && bus_in.addr == 12'h000 |=>
			rdata_out == $past(st_reg.disable_bits) &&
			rdata_out[15:9] == 7'h00 && !rdata_out[7])
		else $error("disable read back wrong");

	unmapped_read_a: assert property (
		bus_in.rd && bus_in.addr != 12'h000 &&
			bus_in.addr != 12'h004 |=> rdata_out == 16'h0000)
		else $error("unmapped read not zero");

	intl_follow_a: assert property (
		std_valid |=> interlace_out == $past(raster_in.interlaced))
		else $error("interlace status does not follow raster");

	lock_status_a: assert property (
		bus_in.rd && bus_in.addr == 12'h004 |=>
			rdata_out[8] == $past(flywheel_lock_in))
		else $error("status lock bit wrong");

	pin_sync_a: assert property (
		$changed(st_reg.pin_q[0]) |->
			$past(st_reg.sync[0][1]) == st_reg.pin_q[0] &&
			$past(st_reg.sync[0][2]) == st_reg.pin_q[0])
		else $error("pin level taken before stages agree");

endmodule

`default_nettype wire

// ---- verif/spc_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.svh"

// ************************************************
// upstream video source and pin drivers
// ************************************************
// levels change only just after an edge, like a real registered source
module spc_source_model (
	input wire logic clock_in,
	input wire logic [4:0] std_sel_in,
	input wire logic [2:0] pins_req_in,
	input wire logic nonzero_req_in,
	output logic proc_pin_out,
	output logic smpte_pin_out,
	output logic lock_pin_out,
	output logic flylock_out,
	output logic nonzero_out,
	output spc_pkg::spc_raster_t raster_out
);
	import spc_pkg::*;

	initial begin
		{proc_pin_out, smpte_pin_out, lock_pin_out} = 3'h0;
		flylock_out = 1'b0;
		nonzero_out = 1'b0;
		raster_out = '0;
	end

	always @(posedge clock_in) begin
		proc_pin_out <= pins_req_in[`SPC_PIN_PROC];
		smpte_pin_out <= pins_req_in[`SPC_PIN_SMPTE];
		lock_pin_out <= pins_req_in[`SPC_PIN_LOCK];
		// flywheel lock tracks the pll lock so status bit 8 moves
		flylock_out <= pins_req_in[`SPC_PIN_LOCK];
		nonzero_out <= nonzero_req_in;
		// rate variants share one raster, so no rate input exists
		case (std_sel_in)
			5'h08: raster_out <= {3'h4, `SPC_TOT_720_24, 12'd1280, 11'd720};
			5'h09: raster_out <= {3'h4, `SPC_TOT_720_24, 12'd3600, 11'd720};
			5'h0e: raster_out <= {3'h4, 13'd2640, 12'd2304, 11'd1080};
			5'h0f: raster_out <= {3'h5, 13'd2640, 12'd2304, 11'd1080};
			5'h12: raster_out <= {3'h4, 13'd2750, 12'd2400, 11'd1080};
			5'h13: raster_out <= {3'h5, 13'd2750, 12'd2400, 11'd1080};
			5'h16: raster_out <= {3'h2, 13'd1716, 12'd1440, 11'd487};
			5'h18: raster_out <= {3'h2, 13'd1728, 12'd1440, 11'd576};
			default: raster_out <= {3'h4, 13'd2200, 12'd1920, 11'd1080};
		endcase
	end
endmodule
`default_nettype wire

// ---- verif/test_spc_proc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.svh"

module test_spc_proc_ctrl;
	import spc_pkg::*;

	logic clock_in, rst_in, p_proc, p_smpte, p_lock, flylock, nonzero;
	logic nz_req;
	logic [2:0] pins_req;
	logic [4:0] std_sel;
	logic [15:0] rdata, d;
	spc_bus_req_t bus;
	spc_raster_t raster;
	spc_feature_en_t feat;
	logic [4:0] code;
	logic intl;
	int bad_count, tests_run;
	logic [4:0] stds [8] = '{5'h08, 5'h09, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h18};

	spc_source_model u_src (.clock_in(clock_in), .std_sel_in(std_sel),
		.pins_req_in(pins_req), .nonzero_req_in(nz_req),
		.proc_pin_out(p_proc), .smpte_pin_out(p_smpte),
		.lock_pin_out(p_lock), .flylock_out(flylock),
		.nonzero_out(nonzero), .raster_out(raster));

	spc_proc_ctrl u_dut (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus),
		.rdata_out(rdata), .processing_enable_pin_in(p_proc),
		.smpte_mode_pin_in(p_smpte), .pll_lock_output_in(p_lock),
		.flywheel_lock_in(flylock), .payload_format_nonzero_in(nonzero),
		.raster_in(raster), .feature_en_out(feat),
		.video_std_code_out(code), .interlace_out(intl));

	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] v);
		@(posedge clock_in);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= v;
		@(posedge clock_in);
		bus.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, output logic [15:0] v);
		@(posedge clock_in);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clock_in);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ************************************************
	// stimulus
	// ************************************************
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end

	initial begin
		#200000;
		bad_count++;
		close_out();
	end

	initial begin
		rst_in = 1'b1;
		bus = '0;
		pins_req = 3'h0;
		nz_req = 1'b0;
		std_sel = 5'h08;
		bad_count = 0;
		tests_run = 0;
		repeat (3) @(posedge clock_in);
		rst_in <= 1'b0;
		rd(`SPC_ADDR_DISABLE, d);
		chk("disable reset", d, 16'h0000);
		rd(`SPC_ADDR_STATUS, d);
		chk("status reset", d, 16'h0000);
		pins_req <= 3'h7;
		nz_req <= 1'b1;
		wr(`SPC_ADDR_DISABLE, 16'hffff);
		rd(`SPC_ADDR_DISABLE, d);
		chk("unused bits", d, 16'h017f);
		settle(10);
		chk("all disabled", 16'(feat), 16'h0080);
		// writes to status and unmapped places leave the map alone
		wr(`SPC_ADDR_STATUS, 16'h0000);
		wr(12'h008, 16'h0000);
		rd(12'h008, d);
		chk("unmapped read", d, 16'h0000);
		rd(`SPC_ADDR_DISABLE, d);
		chk("disable kept", d, 16'h017f);
		wr(`SPC_ADDR_DISABLE, 16'h0000);
		settle(3);
		chk("hd all on", 16'(feat), 16'h006f);
		nz_req <= 1'b0;
		settle(3);
		chk("pid no format", 16'(feat), 16'h002f);
		nz_req <= 1'b1;
		for (int b = 0; b < 9; b++) begin
			if (b != 7) begin
				wr(`SPC_ADDR_DISABLE, 16'h1 << b);
				settle(3);
				chk("one bit off", 16'(feat),
					b == 8 ? 16'h00ef : 16'h006f & ~(16'h1 << b));
			end
		end
		for (int i = 0; i < 8; i++) begin
			std_sel <= stds[i];
			settle(4);
			rd(`SPC_ADDR_STATUS, d);
			chk("std code", {11'h0, d[14:10]}, {11'h0, stds[i]});
			chk("std lock", {15'h0, d[8]}, 16'h0001);
			if (i == 6 || i == 7) begin
				chk("sd interlace", {15'h0, d[9]}, 16'h0001);
			end else if (i != 3 && i != 5) begin
				chk("progressive", {15'h0, d[9]}, 16'h0000);
			end
		end
		wr(`SPC_ADDR_DISABLE, 16'h0000);
		settle(3);
		chk("sd features", 16'(feat), 16'h0039);
		pins_req <= 3'h5;
		settle(10);
		rd(`SPC_ADDR_STATUS, d);
		chk("code no smpte", {10'h0, d[14:9]}, 16'h0000);
		chk("gate no smpte", 16'(feat), 16'h0000);
		pins_req <= 3'h3;
		settle(10);
		rd(`SPC_ADDR_STATUS, d);
		chk("code no lock", {9'h0, d[14:8]}, 16'h0000);
		pins_req <= 3'h6;
		settle(10);
		chk("gate no proc", 16'(feat), 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
